// *** core/tx_channel_source_select.sv ***
// holds the transmit source selector: per-slot control, signaling buffer, slip halves, output queue
// assumes slot strobes and receive-path data come from logic on i_clock, so no synchronisers
`timescale 1ns/100ps
module tx_channel_source_select
(
    input wire logic i_clock,
    input wire logic i_rst,
    // host port
    input wire logic [8:0] i_host_addr,
    input wire logic [7:0] i_host_wdata,
    input wire logic i_host_wr,
    input wire logic i_host_rd,
    output logic [7:0] o_host_rdata,
    output logic o_host_rd_valid,
    // mode
    input wire logic i_t1_mode,
    // system bus slot input
    input wire logic i_slot_valid,
    output logic o_slot_ready,
    input wire logic [4:0] i_slot_index,
    input wire logic i_slot_assigned,
    input wire logic [7:0] i_fbit_mask,
    input wire logic [7:0] i_sysbus_tx_pcm_in,
    input wire logic [3:0] i_sysbus_tx_sig_in,
    // receive path
    input wire logic [7:0] i_receive_path_payload,
    input wire logic [3:0] i_rx_signaling_entry,
    // transmit output
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [4:0] o_out_slot,
    output logic [7:0] o_out_payload,
    output logic [3:0] o_out_sig,
    output logic o_out_sig_insert,
    // E1 multiframe words
    output logic [3:0] o_multiframe_align_word,
    output logic [3:0] o_xyxx_word
);
    // ***************************************
    // state
    // ***************************************
    typedef struct packed
    {
        logic [tx_source_pkg::SLOT_COUNT-1:0][7:0] ctrl;
        logic [tx_source_pkg::SLOT_COUNT-1:0][3:0] tx_sig;
        logic [tx_source_pkg::SLOT_COUNT-1:0][7:0] slip_lo;
        logic [tx_source_pkg::SLOT_COUNT-1:0][7:0] slip_hi;
        logic [7:0] rdata;
        logic rd_valid;
        logic [3:0] align_word;
        logic [3:0] xyxx_word;
    } main_state_type;

    typedef enum logic [2:0]
    {
        REG_NONE = 3'b000,
        REG_CTRL = 3'b001,
        REG_SIG = 3'b010,
        REG_SLIP_LO = 3'b011,
        REG_SLIP_HI = 3'b100
    } region_type;

    main_state_type state_reg;
    main_state_type state_next;
    logic accept;
    logic [7:0] slot_ctrl;
    logic [7:0] mux_payload;
    logic [3:0] mux_sig;
    logic mux_sig_insert;
    logic [tx_source_pkg::FIFO_WIDTH-1:0] fifo_in;
    logic [tx_source_pkg::FIFO_WIDTH-1:0] fifo_out;
    region_type wr_region;
    region_type rd_region;

    // address decode shared by reads and writes
    function automatic region_type decode(input logic [8:0] addr);
        region_type r;
        r = REG_NONE;
        if (addr[8:5] == tx_source_pkg::CTRL_BASE[8:5])
        begin
            r = REG_CTRL;
        end
        else if (addr[8:5] == tx_source_pkg::SIG_BASE[8:5])
        begin
            r = REG_SIG;
        end
        else if (addr[8:5] == tx_source_pkg::SLIP_LO_BASE[8:5])
        begin
            r = REG_SLIP_LO;
        end
        else if (addr[8:5] == tx_source_pkg::SLIP_HI_BASE[8:5])
        begin
            r = REG_SLIP_HI;
        end
        return r;
    endfunction

    assign wr_region = decode(i_host_addr);
    assign rd_region = wr_region;
    assign accept = i_slot_valid && o_slot_ready;
    // the array still holds the old byte in a write cycle, so a slot sees one whole control value
    assign slot_ctrl = state_reg.ctrl[i_slot_index];

    // ***************************************
    // source selection
    // ***************************************
    tx_slot_mux u_mux
    (
        .i_ctrl(slot_ctrl),
        .i_sysbus_byte(i_sysbus_tx_pcm_in),
        .i_idle_byte(state_reg.slip_lo[i_slot_index]),
        .i_rx_byte(i_receive_path_payload),
        .i_tx_sig_entry(state_reg.tx_sig[i_slot_index]),
        .i_rx_sig_entry(i_rx_signaling_entry),
        .i_assigned(i_slot_assigned),
        .i_t1_mode(i_t1_mode),
        .i_fbit_mask(i_fbit_mask),
        .o_payload(mux_payload),
        .o_sig(mux_sig),
        .o_sig_insert(mux_sig_insert)
    );

    assign fifo_in = {i_slot_index, mux_payload, mux_sig, mux_sig_insert};

    // ***************************************
    // output queue
    // ***************************************
    // a stalled consumer fills the queue and then holds off the slot source
    tx_fifo
    #(
        .WIDTH(tx_source_pkg::FIFO_WIDTH),
        .DEPTH(tx_source_pkg::FIFO_DEPTH)
    )
    u_fifo
    (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_in_valid(i_slot_valid),
        .o_in_ready(o_slot_ready),
        .i_in_data(fifo_in),
        .o_out_valid(o_out_valid),
        .i_out_ready(i_out_ready),
        .o_out_data(fifo_out)
    );

    assign o_out_slot = fifo_out[17:13];
    assign o_out_payload = fifo_out[12:5];
    assign o_out_sig = fifo_out[4:1];
    assign o_out_sig_insert = fifo_out[0];
    assign o_host_rdata = state_reg.rdata;
    assign o_host_rd_valid = state_reg.rd_valid;
    assign o_multiframe_align_word = state_reg.align_word;
    assign o_xyxx_word = state_reg.xyxx_word;

    // ***************************************
    // next state
    // ***************************************
    always_comb
    begin
        state_next = state_reg;
        state_next.rd_valid = 1'b0;
        // host writes first, so slot-side stores below win on a clash
        if (i_host_wr)
        begin
            unique case (wr_region)
                REG_CTRL: state_next.ctrl[i_host_addr[4:0]] = i_host_wdata;
                REG_SIG: state_next.tx_sig[i_host_addr[4:0]] = i_host_wdata[3:0];
                REG_SLIP_LO: state_next.slip_lo[i_host_addr[4:0]] = i_host_wdata;
                REG_SLIP_HI: state_next.slip_hi[i_host_addr[4:0]] = i_host_wdata;
                REG_NONE: state_next.rdata = state_reg.rdata;
            endcase
        end
        if (i_host_rd)
        begin
            state_next.rd_valid = 1'b1;
            unique case (rd_region)
                REG_CTRL: state_next.rdata = state_reg.ctrl[i_host_addr[4:0]];
                REG_SIG: state_next.rdata = {4'h0, state_reg.tx_sig[i_host_addr[4:0]]};
                REG_SLIP_LO: state_next.rdata = state_reg.slip_lo[i_host_addr[4:0]];
                REG_SLIP_HI: state_next.rdata = state_reg.slip_hi[i_host_addr[4:0]];
                REG_NONE: state_next.rdata = 8'h00;
            endcase
        end
        if (accept)
        begin
            // entries 0 and 16 are stored by the same path in E1; the multiframe words come from the control bytes
            state_next.tx_sig[i_slot_index] = i_sysbus_tx_sig_in;
            // bytes are kept as received, first bit in bit 7
            state_next.slip_hi[i_slot_index] = i_sysbus_tx_pcm_in;
            if (!slot_ctrl[tx_source_pkg::TX_IDLE_SELECT])
            begin
                state_next.slip_lo[i_slot_index] = i_sysbus_tx_pcm_in;
            end
        end
        // local bits of slots 0 and 16 feed the E1 multiframe words; host keeps C, D equal to A, B for AB-only use
        if (!i_t1_mode)
        begin
            state_next.align_word = state_reg.ctrl[tx_source_pkg::E1_ALIGN_SLOT][3:0];
            state_next.xyxx_word = state_reg.ctrl[tx_source_pkg::E1_XYXX_SLOT][3:0];
        end
        else
        begin
            state_next.align_word = 4'h0;
            state_next.xyxx_word = 4'h0;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg.ctrl <= {tx_source_pkg::SLOT_COUNT{tx_source_pkg::CTRL_RESET}};
            state_reg.tx_sig <= {tx_source_pkg::SLOT_COUNT{tx_source_pkg::SIG_RESET}};
            state_reg.slip_lo <= {tx_source_pkg::SLOT_COUNT{tx_source_pkg::SLIP_RESET}};
            state_reg.slip_hi <= {tx_source_pkg::SLOT_COUNT{tx_source_pkg::SLIP_RESET}};
            state_reg.rdata <= 8'h00;
            state_reg.rd_valid <= 1'b0;
            state_reg.align_word <= 4'h0;
            state_reg.xyxx_word <= 4'h0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end
endmodule

// *** core/tx_source_pkg.sv ***
// holds the constants, field positions and source codes of the transmit source selector
// assumes one framer, 32 time slots, a byte-wide host port and a same-clock slot strobe
package tx_source_pkg;
    // ***************************************
    // host map
    // ***************************************
    localparam logic [8:0] CTRL_BASE = 9'h100;
    localparam logic [8:0] SIG_BASE = 9'h120;
    localparam logic [8:0] SLIP_LO_BASE = 9'h140;
    localparam logic [8:0] SLIP_HI_BASE = 9'h160;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] SIG_RESET = 4'h0;
    localparam logic [7:0] SLIP_RESET = 8'h00;
    localparam int SLOT_COUNT = 32;
    localparam int FIFO_DEPTH = 16;
    // ***************************************
    // control byte fields
    // ***************************************
    localparam int BIT7_ZERO_SUB_EN = 7;
    localparam int EMBEDDED_FBIT_VALUE = 7;
    localparam int REMOTE_CHANNEL_LOOP = 6;
    localparam int TX_IDLE_SELECT = 5;
    localparam int TX_LOCAL_SIG_SELECT = 4;
    localparam int TX_SIGBUF_SELECT = 3;
    localparam int RX_SIGBUF_SELECT = 2;
    localparam int LOCAL_SIG_MSB = 3;
    // ***************************************
    // signaling and payload layout
    // ***************************************
    localparam int SIG_A = 3;
    localparam int SIG_B = 2;
    localparam int SIG_C = 1;
    localparam int SIG_D = 0;
    localparam int SLOT_BIT7_POS = 1;
    localparam logic [4:0] E1_ALIGN_SLOT = 5'h00;
    localparam logic [4:0] E1_XYXX_SLOT = 5'h10;
    localparam int FIFO_WIDTH = 18;

    typedef enum logic [1:0]
    {
        PAY_SYSBUS = 2'b00,
        PAY_IDLE = 2'b01,
        PAY_RX = 2'b10
    } payload_src_type;

    typedef enum logic [1:0]
    {
        SIG_NONE = 2'b00,
        SIG_RXBUF = 2'b01,
        SIG_TXBUF = 2'b10,
        SIG_LOCAL = 2'b11
    } sig_src_type;
endpackage

// *** core/tx_fifo.sv ***
// holds a synchronous first-in first-out buffer with valid and ready on both sides
// assumes a single clock; depth is a power of two
`timescale 1ns/100ps
module tx_fifo
#(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
)
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } fifo_state_type;

    fifo_state_type state_reg;
    fifo_state_type state_next;
    logic push;
    logic pop;

    assign o_in_ready = (state_reg.count != (AW+1)'(DEPTH));
    assign o_out_valid = (state_reg.count != '0);
    assign o_out_data = state_reg.mem[state_reg.rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb
    begin
        state_next = state_reg;
        if (push)
        begin
            state_next.mem[state_reg.wr_ptr] = i_in_data;
            state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
        end
        if (push && !pop)
        begin
            state_next.count = state_reg.count + 1'b1;
        end
        else if (pop && !push)
        begin
            state_next.count = state_reg.count - 1'b1;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end
endmodule

// *** core/tx_slot_mux.sv ***
// holds the per-slot payload and signaling source choice, purely combinational
// assumes the control byte handed in is the one sampled at slot start
`timescale 1ns/100ps
module tx_slot_mux
(
    input wire logic [7:0] i_ctrl,
    input wire logic [7:0] i_sysbus_byte,
    input wire logic [7:0] i_idle_byte,
    input wire logic [7:0] i_rx_byte,
    input wire logic [3:0] i_tx_sig_entry,
    input wire logic [3:0] i_rx_sig_entry,
    input wire logic i_assigned,
    input wire logic i_t1_mode,
    input wire logic [7:0] i_fbit_mask,
    output logic [7:0] o_payload,
    output logic [3:0] o_sig,
    output logic o_sig_insert
);
    tx_source_pkg::payload_src_type pay_src;
    tx_source_pkg::sig_src_type sig_src;
    logic [7:0] raw;

    always_comb
    begin
        pay_src = tx_source_pkg::PAY_SYSBUS;
        // ***************************************
        // payload source
        // ***************************************
        if (i_ctrl[tx_source_pkg::TX_IDLE_SELECT])
        begin
            pay_src = tx_source_pkg::PAY_IDLE;
        end
        else if (i_ctrl[tx_source_pkg::REMOTE_CHANNEL_LOOP])
        begin
            pay_src = tx_source_pkg::PAY_RX;
        end
        unique case (pay_src)
            tx_source_pkg::PAY_SYSBUS: raw = i_sysbus_byte;
            tx_source_pkg::PAY_IDLE: raw = i_idle_byte;
            tx_source_pkg::PAY_RX: raw = i_rx_byte;
            default: raw = i_sysbus_byte;
        endcase
        o_payload = raw;
        // bit 7 of the slot sits at byte bit 1, since bit 7 of the byte goes out first
        if (i_t1_mode && i_assigned && i_ctrl[tx_source_pkg::BIT7_ZERO_SUB_EN] && (raw == 8'h00))
        begin
            o_payload[tx_source_pkg::SLOT_BIT7_POS] = 1'b1;
        end
        if (i_t1_mode && !i_assigned && i_ctrl[tx_source_pkg::TX_IDLE_SELECT])
        begin
            o_payload = (raw & ~i_fbit_mask) |
                (i_fbit_mask & {8{i_ctrl[tx_source_pkg::EMBEDDED_FBIT_VALUE]}});
        end
        // ***************************************
        // signaling source
        // ***************************************
        if (i_ctrl[tx_source_pkg::TX_LOCAL_SIG_SELECT])
        begin
            sig_src = tx_source_pkg::SIG_LOCAL;
        end
        else if (i_ctrl[tx_source_pkg::TX_SIGBUF_SELECT])
        begin
            sig_src = tx_source_pkg::SIG_TXBUF;
        end
        else if (i_ctrl[tx_source_pkg::RX_SIGBUF_SELECT])
        begin
            sig_src = tx_source_pkg::SIG_RXBUF;
        end
        else
        begin
            sig_src = tx_source_pkg::SIG_NONE;
        end
        unique case (sig_src)
            tx_source_pkg::SIG_LOCAL: o_sig = i_ctrl[tx_source_pkg::LOCAL_SIG_MSB:0];
            tx_source_pkg::SIG_TXBUF: o_sig = i_tx_sig_entry;
            tx_source_pkg::SIG_RXBUF: o_sig = i_rx_sig_entry;
            tx_source_pkg::SIG_NONE: o_sig = 4'h0;
        endcase
        o_sig_insert = (sig_src != tx_source_pkg::SIG_NONE);
    end
endmodule

// *** sim/tx_channel_source_select_checker.sv ***
// holds concurrent checks on the transmit source selector ports
// assumes one clock, reset asynchronous and active high
`timescale 1ns/100ps
module tx_channel_source_select_checker
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_host_rd,
    input wire logic [7:0] o_host_rdata,
    input wire logic o_host_rd_valid,
    input wire logic i_t1_mode,
    input wire logic i_slot_valid,
    input wire logic o_slot_ready,
    input wire logic [4:0] i_slot_index,
    input wire logic o_out_valid,
    input wire logic i_out_ready,
    input wire logic [4:0] o_out_slot,
    input wire logic [7:0] o_out_payload,
    input wire logic [3:0] o_out_sig,
    input wire logic o_out_sig_insert,
    input wire logic [3:0] o_multiframe_align_word,
    input wire logic [3:0] o_xyxx_word
);
    // ***************************************
    // properties
    // ***************************************
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    rd_answer_a: assert property (i_host_rd |=> o_host_rd_valid) else $error("read not answered");
    rd_single_a: assert property (!i_host_rd |=> !o_host_rd_valid) else $error("stray read valid");
    rdata_hold_a: assert property (!i_host_rd |=> $stable(o_host_rdata)) else $error("rdata moved");
    head_hold_a: assert property (o_out_valid && !i_out_ready |=> o_out_valid
        && $stable({o_out_slot, o_out_payload, o_out_sig, o_out_sig_insert})) else $error("head changed");
    no_sig_a: assert property (o_out_valid && !o_out_sig_insert |-> o_out_sig == 4'h0)
        else $error("sig without insert");
    t1_words_a: assert property (i_t1_mode |=> o_multiframe_align_word == 4'h0 && o_xyxx_word == 4'h0)
        else $error("e1 words in t1");
    first_word_a: assert property (i_slot_valid && o_slot_ready && !o_out_valid |=> o_out_valid
        && o_out_slot == $past(i_slot_index)) else $error("word late");
    rise_cause_a: assert property ($rose(o_out_valid) |-> $past(i_slot_valid && o_slot_ready))
        else $error("word from nowhere");
    full_cause_a: assert property ($fell(o_slot_ready)
        |-> $past(i_slot_valid) && !$past(i_out_ready && o_out_valid)) else $error("full without push");
    empty_ready_a: assert property (!o_out_valid |-> o_slot_ready) else $error("empty but refused");
    full_c: cover property (!o_slot_ready);
    read_c: cover property (o_host_rd_valid);
    stall_c: cover property (o_out_valid && !i_out_ready);
endmodule
bind tx_channel_source_select tx_channel_source_select_checker CHK (.i_clock, .i_rst, .i_host_rd, .o_host_rdata,
    .o_host_rd_valid, .i_t1_mode, .i_slot_valid, .o_slot_ready, .i_slot_index, .o_out_valid, .i_out_ready,
    .o_out_slot, .o_out_payload, .o_out_sig, .o_out_sig_insert, .o_multiframe_align_word, .o_xyxx_word);

// *** sim/tx_sink_model.sv ***
// holds a behavioural sink for the transmit output queue
// assumes the block's clock and reset; stall holds ready low
`timescale 1ns/100ps
module tx_sink_model
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_stall,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [17:0] i_word
);
    // ***************************************
    // capture
    // ***************************************
    logic [17:0] q[$];
    // ready is registered, so a stall shows one cycle late
    always @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_ready <= 1'b0;
        else
        begin
            if (i_valid && o_ready)
                q.push_back(i_word);
            o_ready <= !i_stall;
        end
    end
endmodule

// *** sim/tx_channel_source_select_bench.sv ***
// holds the self-checking bench of the transmit source selector
// assumes the sink model on the output queue and a 50 MHz clock
`timescale 1ns/100ps
module tx_channel_source_select_bench;
    logic i_clock, i_rst, i_host_wr, i_host_rd, i_t1_mode, i_slot_valid, i_slot_assigned, i_stall, out_ready;
    logic [8:0] i_host_addr;
    logic [7:0] i_host_wdata, i_fbit_mask, i_sysbus_tx_pcm_in, i_receive_path_payload, o_host_rdata, o_out_payload;
    logic [4:0] i_slot_index, o_out_slot;
    logic [3:0] i_sysbus_tx_sig_in, i_rx_signaling_entry, o_out_sig, o_multiframe_align_word, o_xyxx_word;
    logic o_host_rd_valid, o_slot_ready, o_out_valid, o_out_sig_insert;
    int n_fail, total_checks, cycles;
    tx_channel_source_select DUT (.i_clock, .i_rst, .i_host_addr, .i_host_wdata, .i_host_wr, .i_host_rd,
        .o_host_rdata, .o_host_rd_valid, .i_t1_mode, .i_slot_valid, .o_slot_ready, .i_slot_index,
        .i_slot_assigned, .i_fbit_mask, .i_sysbus_tx_pcm_in, .i_sysbus_tx_sig_in, .i_receive_path_payload,
        .i_rx_signaling_entry, .o_out_valid, .i_out_ready(out_ready), .o_out_slot, .o_out_payload, .o_out_sig,
        .o_out_sig_insert, .o_multiframe_align_word, .o_xyxx_word);
    tx_sink_model M (.i_clock, .i_rst, .i_stall, .i_valid(o_out_valid), .o_ready(out_ready),
        .i_word({o_out_slot, o_out_payload, o_out_sig, o_out_sig_insert}));
    // ***************************************
    // shared tasks
    // ***************************************
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_host_addr <= a;
        i_host_wdata <= d;
        i_host_wr <= 1'b1;
        @(posedge i_clock);
        i_host_wr <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        @(posedge i_clock);
        i_host_addr <= a;
        i_host_rd <= 1'b1;
        @(posedge i_clock);
        i_host_rd <= 1'b0;
        #1;
        chk("rdata", {9'h0, 1'b1, e}, {9'h0, o_host_rd_valid, o_host_rdata});
    endtask
    // word is {slot, payload, sig, insert}; w waits for it at the sink
    task automatic snd(input logic [4:0] s, input logic [7:0] p, input logic [3:0] g, input logic [7:0] r,
        input logic [3:0] rg, input logic [17:0] e, input bit w);
        int n;
        n = M.q.size();
        @(posedge i_clock);
        i_slot_valid <= 1'b1;
        i_slot_index <= s;
        i_sysbus_tx_pcm_in <= p;
        i_sysbus_tx_sig_in <= g;
        i_receive_path_payload <= r;
        i_rx_signaling_entry <= rg;
        @(posedge i_clock);
        while (o_slot_ready !== 1'b1)
            @(posedge i_clock);
        i_slot_valid <= 1'b0;
        if (w)
        begin
            for (int k = 0; k < 40 && M.q.size() <= n; k++)
                @(posedge i_clock);
            chk("word", e, M.q.size() > n ? M.q[n] : 18'hx);
        end
    endtask
    // ***************************************
    // scenarios
    // ***************************************
    task automatic t_reset;
        rd(9'h100, 8'h00);
        rd(9'h120, 8'h00);
        rd(9'h140, 8'h00);
        rd(9'h1ff, 8'h00);
    endtask
    task automatic t_payload;
        logic [7:0] c[4] = '{8'h00, 8'h20, 8'h40, 8'h60};
        logic [7:0] e[4] = '{8'h3c, 8'ha5, 8'hc3, 8'ha5};
        for (int k = 0; k < 4; k++)
        begin
            wr(9'h143, 8'ha5);
            wr(9'h103, c[k]);
            snd(5'h03, 8'h3c, 4'h0, 8'hc3, 4'h0, {5'h03, e[k], 4'h0, 1'b0}, 1'b1);
        end
        rd(9'h143, 8'ha5);
        rd(9'h163, 8'h3c);
    endtask
    task automatic t_sig;
        wr(9'h125, 8'h05);
        wr(9'h105, 8'h15);
        snd(5'h05, 8'h11, 4'h9, 8'h77, 4'h6, {5'h05, 8'h11, 4'h5, 1'b1}, 1'b1);
        wr(9'h105, 8'h08);
        snd(5'h05, 8'h11, 4'h3, 8'h77, 4'h6, {5'h05, 8'h11, 4'h9, 1'b1}, 1'b1);
        rd(9'h125, 8'h03);
        wr(9'h105, 8'h44);
        snd(5'h05, 8'h11, 4'h3, 8'h77, 4'h6, {5'h05, 8'h77, 4'h6, 1'b1}, 1'b1);
        wr(9'h105, 8'h00);
        snd(5'h05, 8'h11, 4'h3, 8'h77, 4'h6, {5'h05, 8'h11, 4'h0, 1'b0}, 1'b1);
    endtask
    task automatic t_t1;
        i_t1_mode <= 1'b1;
        wr(9'h109, 8'h80);
        snd(5'h09, 8'h00, 4'h0, 8'h00, 4'h0, {5'h09, 8'h02, 4'h0, 1'b0}, 1'b1);
        snd(5'h09, 8'h01, 4'h0, 8'h00, 4'h0, {5'h09, 8'h01, 4'h0, 1'b0}, 1'b1);
        i_slot_assigned <= 1'b0;
        i_fbit_mask <= 8'h01;
        wr(9'h149, 8'h00);
        wr(9'h109, 8'ha0);
        snd(5'h09, 8'h00, 4'h0, 8'h00, 4'h0, {5'h09, 8'h01, 4'h0, 1'b0}, 1'b1);
        wr(9'h149, 8'hff);
        wr(9'h109, 8'h20);
        snd(5'h09, 8'h00, 4'h0, 8'h00, 4'h0, {5'h09, 8'hfe, 4'h0, 1'b0}, 1'b1);
        i_t1_mode <= 1'b0;
        i_slot_assigned <= 1'b1;
        i_fbit_mask <= 8'h00;
    endtask
    task automatic t_e1;
        wr(9'h100, 8'h09);
        wr(9'h110, 8'h06);
        repeat (2) @(posedge i_clock);
        #1;
        chk("e1_words", 18'h96, {10'h0, o_multiframe_align_word, o_xyxx_word});
        snd(5'h00, 8'h00, 4'h5, 8'h00, 4'h0, {5'h00, 8'h00, 4'h0, 1'b1}, 1'b1);
        rd(9'h120, 8'h05);
    endtask
    task automatic t_fill;
        int n;
        n = M.q.size();
        i_stall <= 1'b1;
        repeat (2) @(posedge i_clock);
        for (int k = 16; k < 32; k++)
            snd(5'(k), 8'h00, 4'h0, 8'h00, 4'h0, 18'h0, 1'b0);
        @(posedge i_clock);
        #1;
        chk("slot_ready", 18'h0, {17'h0, o_slot_ready});
        i_stall <= 1'b0;
        for (int k = 0; k < 60 && M.q.size() < n + 16; k++)
            @(posedge i_clock);
        for (int k = 0; k < 16; k++)
            chk("order", 18'(16 + k), M.q.size() > n + k ? 18'(M.q[n + k][17:13]) : 18'hx);
    endtask
    // ***************************************
    // run
    // ***************************************
    initial
    begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    // a hang counts as a mismatch
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            conclude();
        end
    end
    initial
    begin
        {i_host_wr, i_host_rd, i_t1_mode, i_slot_valid, i_stall} = 5'h00;
        i_rst = 1'b1;
        i_slot_assigned = 1'b1;
        {i_host_addr, i_host_wdata, i_fbit_mask, i_sysbus_tx_pcm_in, i_receive_path_payload} = 41'h0;
        {i_slot_index, i_sysbus_tx_sig_in, i_rx_signaling_entry} = 13'h0;
        repeat (12) @(posedge i_clock);
        i_rst <= 1'b0;
        t_reset();
        t_payload();
        t_sig();
        t_t1();
        t_e1();
        t_fill();
        conclude();
    end
endmodule
